// *** shared/arx_pkg.sv ***
// Constants for the asynchronous receive DMA context registers
`default_nettype none

package arx_pkg;
   // Contexts and their register spacing
   localparam int NUM_CTX = 2;
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTX_STRIDE = 12'h020;
   localparam logic [11:0] OFS_CTL_SET = 12'h1C0;
   localparam logic [11:0] OFS_CTL_CLR = 12'h1C4;
   localparam logic [11:0] OFS_CMD_PTR = 12'h1CC;

   // Control register field positions
   localparam int RUN_BIT = 15;
   localparam int WAKE_BIT = 12;
   localparam int DEAD_BIT = 11;
   localparam int ACTIVE_BIT = 10;
   localparam int SPD_LSB = 5;
   localparam int SPD_W = 3;
   localparam int EVT_LSB = 0;
   localparam int EVT_W = 5;

   // Command pointer field positions
   localparam int PTR_ADDR_LSB = 4;
   localparam int PTR_Z_W = 4;

   // Reset values
   localparam logic RUN_RST = 1'b0;
   localparam logic WAKE_RST = 1'b0;
   localparam logic DEAD_RST = 1'b0;
   localparam logic ACTIVE_RST = 1'b0;
   localparam logic [2:0] SPD_RST = 3'h0;
   localparam logic [4:0] EVT_RST = 5'h00;
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Speed codes of the last received packet
   localparam logic [2:0] SPD_100 = 3'h0;
   localparam logic [2:0] SPD_200 = 3'h1;
   localparam logic [2:0] SPD_400 = 3'h2;

   // Empty program marker in the pointer low field
   localparam logic [3:0] Z_EMPTY = 4'h0;
endpackage : arx_pkg

`default_nettype wire

// *** logic/arx_ctx_ctl.sv ***
// Control and status bits of one receive DMA context
`default_nettype none

module arx_ctx_ctl (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic set_wr,
   input wire logic clr_wr,
   input wire logic [31:0] wdata,
   input wire logic desc_fetch,
   input wire logic fatal_err,
   input wire logic engine_busy,
   input wire logic pkt_done,
   input wire logic [2:0] pkt_spd,
   input wire logic [4:0] pkt_evt,
   output logic [31:0] ctl_value,
   output logic run,
   output logic wake,
   output logic start
);
   logic run_q, run_d;
   logic wake_q, wake_d;
   logic dead_q, dead_d;
   logic active_q, active_d;
   logic start_q, start_d;
   logic [2:0] spd_q, spd_d;
   logic [4:0] evt_q, evt_d;
   logic run_clear;

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the control bits
   always_comb begin
      run_clear = clr_wr & wdata[arx_pkg::RUN_BIT] & run_q;
      run_d = run_q;
      wake_d = wake_q;
      dead_d = dead_q;
      spd_d = spd_q;
      evt_d = evt_q;
      if (soft_rst) begin
         run_d = arx_pkg::RUN_RST;
         wake_d = arx_pkg::WAKE_RST;
         dead_d = arx_pkg::DEAD_RST;
         spd_d = arx_pkg::SPD_RST;
         evt_d = arx_pkg::EVT_RST;
      end else begin
         // Only run and wake are software writable; dead also clears on a run clear write, all else ignores writes
         if (set_wr && wdata[arx_pkg::RUN_BIT]) begin
            run_d = 1'b1;
         end
         if (clr_wr && wdata[arx_pkg::RUN_BIT]) begin
            run_d = 1'b0;
         end
         // Software set beats a fetch in the same cycle
         if (set_wr && wdata[arx_pkg::WAKE_BIT]) begin
            wake_d = 1'b1;
         end else if (desc_fetch) begin
            wake_d = 1'b0;
         end
         // Fatal error beats the clear that comes with run going low
         if (fatal_err && run_q) begin
            dead_d = 1'b1;
         end else if (run_clear) begin
            dead_d = 1'b0;
         end
         if (pkt_done) begin
            spd_d = pkt_spd;
            evt_d = pkt_evt;
         end
      end
      active_d = run_q & engine_busy & ~dead_q & ~soft_rst;
      start_d = run_d & ~run_q;
   end

   // Register the control bits
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= arx_pkg::RUN_RST;
         wake_q <= arx_pkg::WAKE_RST;
         dead_q <= arx_pkg::DEAD_RST;
         active_q <= arx_pkg::ACTIVE_RST;
         start_q <= 1'b0;
         spd_q <= arx_pkg::SPD_RST;
         evt_q <= arx_pkg::EVT_RST;
      end else begin
         run_q <= run_d;
         wake_q <= wake_d;
         dead_q <= dead_d;
         active_q <= active_d;
         start_q <= start_d;
         spd_q <= spd_d;
         evt_q <= evt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assemble the readable word; reserved bits stay zero
   always_comb begin
      ctl_value = 32'h0000_0000;
      ctl_value[arx_pkg::RUN_BIT] = run_q;
      ctl_value[arx_pkg::WAKE_BIT] = wake_q;
      ctl_value[arx_pkg::DEAD_BIT] = dead_q;
      ctl_value[arx_pkg::ACTIVE_BIT] = active_q;
      ctl_value[arx_pkg::SPD_LSB +: arx_pkg::SPD_W] = spd_q;
      ctl_value[arx_pkg::EVT_LSB +: arx_pkg::EVT_W] = evt_q;
   end

   assign run = run_q;
   assign wake = wake_q;
   assign start = start_q;
endmodule : arx_ctx_ctl

`default_nettype wire

// *** logic/arx_cmd_ptr.sv ***
// Command pointer register of one receive DMA context
`default_nettype none

module arx_cmd_ptr (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic ptr_wr,
   input wire logic [31:0] wdata,
   input wire logic hw_load,
   input wire logic [31:0] hw_value,
   input wire logic run,
   input wire logic active,
   output logic [31:0] ptr_value
);
   logic [31:0] ptr_q, ptr_d;

   ////////////////////////////////////////////////////////////////////////////
   // Next pointer: engine update first, software only while stopped
   always_comb begin
      ptr_d = ptr_q;
      if (soft_rst) begin
         ptr_d = arx_pkg::PTR_RST;
      end else if (hw_load) begin
         ptr_d = hw_value;
      end else if (ptr_wr && !run && !active) begin
         ptr_d = wdata;
      end
   end

   // Register the pointer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q <= arx_pkg::PTR_RST;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   assign ptr_value = ptr_q;
endmodule : arx_cmd_ptr

`default_nettype wire

// *** logic/arx_async_rx_regs.sv ***
// Register bank for the request and response receive DMA contexts
`default_nettype none

module arx_async_rx_regs #(
   parameter int NUM_CTX = arx_pkg::NUM_CTX,
   parameter int ADDR_W = arx_pkg::ADDR_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [NUM_CTX-1:0] desc_fetch,
   input wire logic [NUM_CTX-1:0] fatal_err,
   input wire logic [NUM_CTX-1:0] engine_busy,
   input wire logic [NUM_CTX-1:0] pkt_done,
   input wire logic [NUM_CTX-1:0][2:0] pkt_spd,
   input wire logic [NUM_CTX-1:0][4:0] pkt_evt,
   input wire logic [NUM_CTX-1:0] ptr_load,
   input wire logic [NUM_CTX-1:0][31:0] ptr_load_value,
   output logic [NUM_CTX-1:0] ctx_run,
   output logic [NUM_CTX-1:0] ctx_wake,
   output logic [NUM_CTX-1:0] ctx_start,
   output logic [NUM_CTX-1:0][31:0] ctx_start_addr,
   output logic [NUM_CTX-1:0] ctx_start_valid
);
   // Only the request and response contexts exist in this window of the map
   if (NUM_CTX < 1 || NUM_CTX > 2) begin : g_bad_ctx
      $error("NUM_CTX must be 1 or 2");
   end
   if (ADDR_W < 9) begin : g_bad_addr
      $error("ADDR_W too narrow for the register offsets");
   end

   logic [NUM_CTX-1:0] hit_set, hit_clr, hit_ptr;
   logic [NUM_CTX-1:0][31:0] ctl_word;
   logic [NUM_CTX-1:0][31:0] ptr_word;
   logic [NUM_CTX-1:0] run_w, start_w, active_w;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic [NUM_CTX-1:0] start_q, start_d;
   logic [NUM_CTX-1:0][31:0] start_addr_q, start_addr_d;
   logic [NUM_CTX-1:0] start_valid_q, start_valid_d;

   ////////////////////////////////////////////////////////////////////////////
   // One register copy per context at a fixed stride
   for (genvar i = 0; i < NUM_CTX; i++) begin : g_ctx
      localparam logic [11:0] BASE_OFS = 12'(i * arx_pkg::CTX_STRIDE);
      localparam logic [11:0] SET_OFS = 12'(arx_pkg::OFS_CTL_SET + BASE_OFS);
      localparam logic [11:0] CLR_OFS = 12'(arx_pkg::OFS_CTL_CLR + BASE_OFS);
      localparam logic [11:0] PTR_OFS = 12'(arx_pkg::OFS_CMD_PTR + BASE_OFS);

      // Full address match, so misaligned addresses hit nothing
      assign hit_set[i] = (reg_addr == ADDR_W'(SET_OFS));
      assign hit_clr[i] = (reg_addr == ADDR_W'(CLR_OFS));
      assign hit_ptr[i] = (reg_addr == ADDR_W'(PTR_OFS));

      arx_ctx_ctl u_ctl (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .soft_rst(soft_rst),
         .set_wr(reg_wr & hit_set[i]),
         .clr_wr(reg_wr & hit_clr[i]),
         .wdata(reg_wdata),
         .desc_fetch(desc_fetch[i]),
         .fatal_err(fatal_err[i]),
         .engine_busy(engine_busy[i]),
         .pkt_done(pkt_done[i]),
         .pkt_spd(pkt_spd[i]),
         .pkt_evt(pkt_evt[i]),
         .ctl_value(ctl_word[i]),
         .run(run_w[i]),
         .wake(ctx_wake[i]),
         .start(start_w[i])
      );

      assign active_w[i] = ctl_word[i][arx_pkg::ACTIVE_BIT];

      arx_cmd_ptr u_ptr (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .soft_rst(soft_rst),
         .ptr_wr(reg_wr & hit_ptr[i]),
         .wdata(reg_wdata),
         .hw_load(ptr_load[i]),
         .hw_value(ptr_load_value[i]),
         .run(run_w[i]),
         .active(active_w[i]),
         .ptr_value(ptr_word[i])
      );
   end

   assign ctx_run = run_w;

   ////////////////////////////////////////////////////////////////////////////
   // Read data selection; unmapped addresses return zero
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         rdata_d = arx_pkg::RDATA_RST;
         for (int k = 0; k < NUM_CTX; k++) begin
            if (hit_set[k] || hit_clr[k]) begin
               rdata_d = ctl_word[k];
            end
            if (hit_ptr[k]) begin
               rdata_d = ptr_word[k];
            end
         end
      end
   end

   // Register the read answer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= arx_pkg::RDATA_RST;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Start request to the engine: aligned program address and its validity
   always_comb begin
      start_addr_d = start_addr_q;
      start_valid_d = start_valid_q;
      start_d = start_w & ~{NUM_CTX{soft_rst}};
      for (int k = 0; k < NUM_CTX; k++) begin
         if (soft_rst) begin
            start_addr_d[k] = arx_pkg::PTR_RST;
            start_valid_d[k] = 1'b0;
         end else if (start_w[k]) begin
            start_addr_d[k] = {ptr_word[k][31:arx_pkg::PTR_ADDR_LSB], 4'h0};
            start_valid_d[k] = (ptr_word[k][arx_pkg::PTR_Z_W-1:0] != arx_pkg::Z_EMPTY);
         end
      end
   end

   // Register the start request
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_q <= '0;
         start_addr_q <= '0;
         start_valid_q <= '0;
      end else begin
         start_q <= start_d;
         start_addr_q <= start_addr_d;
         start_valid_q <= start_valid_d;
      end
   end

   assign ctx_start = start_q;
   assign ctx_start_addr = start_addr_q;
   assign ctx_start_valid = start_valid_q;
endmodule : arx_async_rx_regs

`default_nettype wire

// *** verif/arx_async_rx_regs_asserts.sv ***
// Checker for the receive DMA context register bank
`default_nettype none
module arx_async_rx_regs_asserts #(
   parameter int NUM_CTX = 2,
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [NUM_CTX-1:0] desc_fetch,
   input wire logic [NUM_CTX-1:0] ctx_run,
   input wire logic [NUM_CTX-1:0] ctx_wake,
   input wire logic [NUM_CTX-1:0] ctx_start,
   input wire logic [NUM_CTX-1:0][31:0] ctx_start_addr
);
   // Alias writes to the request context
   logic set_w;
   logic clr_w;
   assign set_w = reg_wr && !soft_rst && reg_addr == 12'h1C0;
   assign clr_w = reg_wr && !soft_rst && reg_addr == 12'h1C4;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Run rising from a set write, then the start pulse
   sequence run_up_s; set_w && reg_wdata[15] && !ctx_run[0]; endsequence
   sequence no_srst_s; !soft_rst; endsequence
   run_set_a: assert property (set_w && reg_wdata[15] |=> ctx_run[0]) else $error("run not set");
   run_clr_a: assert property (clr_w && reg_wdata[15] |=> !ctx_run[0]) else $error("run not cleared");
   run_hold_a: assert property (ctx_run[0] && !soft_rst && !(clr_w && reg_wdata[15]) |=> ctx_run[0])
      else $error("run dropped");
   wake_set_a: assert property (set_w && reg_wdata[12] |=> ctx_wake[0]) else $error("wake not set");
   wake_fetch_a: assert property (desc_fetch[0] && !soft_rst && !(set_w && reg_wdata[12]) |=> !ctx_wake[0])
      else $error("wake kept");
   start_run_a: assert property (run_up_s ##1 no_srst_s |=> ctx_start[0]) else $error("no start");
   start_align_a: assert property (ctx_start[0] |-> ctx_start_addr[0][3:0] == 4'h0) else $error("unaligned");
   read_valid_a: assert property (reg_rd |=> reg_rvalid) else $error("no read valid");
   rsvd_zero_a: assert property (reg_rd && (reg_addr == 12'h1C0 || reg_addr == 12'h1C4)
      |=> (reg_rdata & 32'hFFFF6300) == 32'h0) else $error("reserved bits set");
endmodule // arx_async_rx_regs_asserts
bind arx_async_rx_regs arx_async_rx_regs_asserts #(.NUM_CTX(NUM_CTX), .ADDR_W(ADDR_W)) arx_async_rx_regs_asserts_inst (
   .sys_clk(sys_clk), .rst_b(rst_b), .soft_rst(soft_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .desc_fetch(desc_fetch), .ctx_run(ctx_run), .ctx_wake(ctx_wake), .ctx_start(ctx_start),
   .ctx_start_addr(ctx_start_addr));
`default_nettype wire

// *** verif/arx_async_rx_regs_bench.sv ***
// Self-checking bench for the receive DMA context register bank
`default_nettype none
module arx_async_rx_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic soft_rst = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic [1:0] desc_fetch = 2'h0;
   logic [1:0] fatal_err = 2'h0;
   logic [1:0] engine_busy = 2'h0;
   logic [1:0] pkt_done = 2'h0;
   logic [1:0][2:0] pkt_spd = 6'h00;
   logic [1:0][4:0] pkt_evt = 10'h000;
   logic [1:0] ptr_load = 2'h0;
   logic [1:0][31:0] ptr_load_value = 64'h0;
   logic [1:0] ctx_run;
   logic [1:0] ctx_wake;
   logic [1:0] ctx_start;
   logic [1:0][31:0] ctx_start_addr;
   logic [1:0] ctx_start_valid;
   int fail_count = 0;
   int tests_run = 0;
   logic [31:0] rng = 32'h50D15741;
   logic [31:0] m_ctl [2] = '{32'h0, 32'h0};
   logic [31:0] m_ptr [2] = '{32'h0, 32'h0};
   logic [11:0] b;
   arx_async_rx_regs arx_async_rx_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .soft_rst(soft_rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .desc_fetch(desc_fetch), .fatal_err(fatal_err), .engine_busy(engine_busy),
      .pkt_done(pkt_done), .pkt_spd(pkt_spd), .pkt_evt(pkt_evt), .ptr_load(ptr_load),
      .ptr_load_value(ptr_load_value), .ctx_run(ctx_run), .ctx_wake(ctx_wake), .ctx_start(ctx_start),
      .ctx_start_addr(ctx_start_addr), .ctx_start_valid(ctx_start_valid));
   // Free-running clock
   always #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////
   function logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // Model control value, active from run, busy and dead
   function logic [31:0] ectl(input int c);
      logic [31:0] v;
      v = m_ctl[c];
      v[10] = v[15] & engine_busy[c] & ~v[11];
      return v;
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Register write that also updates the model
   task mwr(input int c, input logic [11:0] o, input logic [31:0] d);
      logic [31:0] v;
      v = ectl(c);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = b + o;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      if (o == 12'h000) m_ctl[c] |= d & 32'h9000;
      if (o == 12'h004 && d[15]) m_ctl[c][15:11] = 5'h02 & m_ctl[c][15:11];
      if (o == 12'h00C && !v[15] && !v[10]) m_ptr[c] = d;
   endtask
   // Register read with bounded wait for the answer
   task rd(input logic [11:0] a, input logic [31:0] exp);
      int n;
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 4) begin
         fail_count++;
         tally_and_finish();
      end
      check(reg_rdata, exp);
   endtask
   task readall(input int c);
      rd(b, ectl(c));
      rd(b + 12'h004, ectl(c));
      rd(b + 12'h008, 32'h0);
      rd(b + 12'h00C, m_ptr[c]);
      check({30'h0, ctx_run[c], ctx_wake[c]}, {30'h0, m_ctl[c][15], m_ctl[c][12]});
   endtask
   // One-cycle engine event pulses
   task pulse(input int c, input logic f, input logic e, input logic d, input logic l);
      @(negedge sys_clk);
      desc_fetch[c] = f;
      fatal_err[c] = e;
      pkt_done[c] = d;
      pkt_spd[c] = 3'(xs() % 3);
      pkt_evt[c] = 5'(xs());
      ptr_load[c] = l;
      ptr_load_value[c] = xs();
      @(negedge sys_clk);
      desc_fetch = 2'h0;
      fatal_err = 2'h0;
      pkt_done = 2'h0;
      ptr_load = 2'h0;
      if (f) m_ctl[c][12] = 1'b0;
      if (e && m_ctl[c][15]) m_ctl[c][11] = 1'b1;
      if (d) m_ctl[c][7:0] = {pkt_spd[c], pkt_evt[c]};
      if (l) m_ptr[c] = ptr_load_value[c];
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      for (int c = 0; c < 2; c++) begin
         b = c ? 12'h1E0 : 12'h1C0;
         readall(c);
         mwr(c, 12'h00C, xs());
         readall(c);
         pulse(c, 1'b0, 1'b0, 1'b0, 1'b1);
         mwr(c, 12'h000, 32'hFFFFFFFF);
         @(negedge sys_clk);
         check({31'h0, ctx_start[c]}, 32'h1);
         check(ctx_start_addr[c], {m_ptr[c][31:4], 4'h0});
         check({31'h0, ctx_start_valid[c]}, {31'h0, m_ptr[c][3:0] != 4'h0});
         mwr(c, 12'h00C, xs());
         readall(c);
         engine_busy[c] = 1'b1;
         pulse(c, 1'b1, 1'b0, 1'b1, 1'b0);
         readall(c);
         pulse(c, 1'b0, 1'b1, 1'b1, 1'b0);
         readall(c);
         mwr(c, 12'h004, 32'hFFFFFFFF);
         engine_busy[c] = 1'b0;
         readall(c);
         $display("Context %0d test done", c);
      end
      @(negedge sys_clk);
      soft_rst = 1'b1;
      @(negedge sys_clk);
      soft_rst = 1'b0;
      m_ctl = '{32'h0, 32'h0};
      m_ptr = '{32'h0, 32'h0};
      for (int c = 0; c < 2; c++) begin
         b = c ? 12'h1E0 : 12'h1C0;
         readall(c);
      end
      $display("Software reset test done");
      tally_and_finish();
   end
   // Watchdog for the whole run
   initial begin
      #2000000;
      fail_count++;
      tally_and_finish();
   end
endmodule // arx_async_rx_regs_bench
`default_nettype wire
